// ---- verilog/autoneg_base_page_advert_regs.sv ----
// Autonegotiation base page advertisement register bank, bits 31:0
`timescale 1ns/1ps

module autoneg_base_page_advert_regs
(
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   input wire logic [4:0] I_MMD_DEV,
   input wire logic [15:0] I_REG_ADDR,
   input wire logic I_WR_EN,
   input wire logic [15:0] I_WR_DATA,
   input wire logic I_RD_EN,
   input wire logic I_ROLE_STRAP,
   input wire logic I_PAGE_RECEIVED,
   input wire logic I_AN_RESTART,
   input wire logic [4:0] I_NONCE_SEED,
   output logic [15:0] O_RD_DATA,
   output logic O_RD_VALID,
   output logic [31:0] O_ADV_PAGE,
   output logic [4:0] O_TX_NONCE
);

   typedef struct packed {
      autoneg_advert_pkg::boot_type boot;
      logic next_page;
      logic ack;
      logic remote_fault;
      logic role_forced;
      logic [1:0] pause;
      logic long_reach;
      logic leader;
      logic [15:0] rd_data;
      logic rd_valid;
      logic [31:0] page;
      logic [4:0] nonce;
   } state_type;

   state_type state;
   state_type next_state;
   logic [15:0] cur_low;
   logic [15:0] cur_mid;
   logic [15:0] new_low;
   logic [15:0] new_mid;
   logic sel_dev;
   logic hit_low;
   logic hit_mid;

   // Word images of the held fields
   function automatic logic [15:0] low_image(input state_type s);
      logic [15:0] w;
      w = 16'h0000;
      w[autoneg_advert_pkg::POS_NEXT_PAGE] = s.next_page;
      w[autoneg_advert_pkg::POS_ACK] = s.ack;
      w[autoneg_advert_pkg::POS_REMOTE_FAULT] = s.remote_fault;
      w[autoneg_advert_pkg::POS_ROLE_FORCED] = s.role_forced;
      w[autoneg_advert_pkg::POS_PAUSE_HI:autoneg_advert_pkg::POS_PAUSE_LO] = s.pause;
      w[autoneg_advert_pkg::POS_SEL_HI:autoneg_advert_pkg::POS_SEL_LO] = autoneg_advert_pkg::SELECTOR_IEEE;
      return w;
   endfunction : low_image

   function automatic logic [15:0] mid_image(input state_type s);
      logic [15:0] w;
      w = 16'h0000;
      w[autoneg_advert_pkg::POS_LONG_REACH] = s.long_reach;
      w[autoneg_advert_pkg::POS_LEADER] = s.leader;
      return w;
   endfunction : mid_image

   always_comb
   begin
      next_state = state;
      sel_dev = (I_MMD_DEV == autoneg_advert_pkg::MMD_AUTONEG);
      if (sel_dev && (I_REG_ADDR == autoneg_advert_pkg::ADDR_ADV_LOW))
      begin
         hit_low = 1'b1;
         hit_mid = 1'b0;
      end
      else if (sel_dev && (I_REG_ADDR == autoneg_advert_pkg::ADDR_ADV_MID))
      begin
         hit_low = 1'b0;
         hit_mid = 1'b1;
      end
      else
      begin
         hit_low = 1'b0;
         hit_mid = 1'b0;
      end
      cur_low = low_image(state);
      cur_mid = mid_image(state);
      next_state.boot = autoneg_advert_pkg::BOOT_RUN;
      if (I_WR_EN && hit_low)
      begin
         next_state.next_page = I_WR_DATA[autoneg_advert_pkg::POS_NEXT_PAGE];
         next_state.remote_fault = I_WR_DATA[autoneg_advert_pkg::POS_REMOTE_FAULT];
         next_state.role_forced = I_WR_DATA[autoneg_advert_pkg::POS_ROLE_FORCED];
         next_state.pause = I_WR_DATA[autoneg_advert_pkg::POS_PAUSE_HI:autoneg_advert_pkg::POS_PAUSE_LO];
      end
      if (I_WR_EN && hit_mid)
      begin
         next_state.long_reach = I_WR_DATA[autoneg_advert_pkg::POS_LONG_REACH];
         next_state.leader = I_WR_DATA[autoneg_advert_pkg::POS_LEADER];
      end
      if (state.boot == autoneg_advert_pkg::BOOT_STRAP)
      begin
         next_state.leader = I_ROLE_STRAP;
      end
      if (I_PAGE_RECEIVED)
      begin
         next_state.ack = 1'b1;
      end
      else if (I_AN_RESTART)
      begin
         next_state.ack = 1'b0;
      end
      next_state.rd_valid = I_RD_EN;
      if (I_RD_EN && hit_low)
      begin
         next_state.rd_data = cur_low;
      end
      else if (I_RD_EN && hit_mid)
      begin
         next_state.rd_data = cur_mid;
      end
      else
      begin
         next_state.rd_data = 16'h0000;
      end
      new_low = low_image(next_state);
      new_mid = mid_image(next_state);
      next_state.page = {new_mid, new_low};
      next_state.nonce = I_NONCE_SEED;
      next_state.nonce[autoneg_advert_pkg::POS_NONCE_ROLE] = next_state.leader;
   end

   always_ff @(posedge I_REF_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         state.boot <= autoneg_advert_pkg::BOOT_STRAP;
         state.next_page <= autoneg_advert_pkg::RST_ADV_LOW[autoneg_advert_pkg::POS_NEXT_PAGE];
         state.ack <= autoneg_advert_pkg::RST_ADV_LOW[autoneg_advert_pkg::POS_ACK];
         state.remote_fault <= autoneg_advert_pkg::RST_ADV_LOW[autoneg_advert_pkg::POS_REMOTE_FAULT];
         state.role_forced <= autoneg_advert_pkg::RST_ADV_LOW[autoneg_advert_pkg::POS_ROLE_FORCED];
         state.pause <= autoneg_advert_pkg::RST_ADV_LOW[autoneg_advert_pkg::POS_PAUSE_HI:autoneg_advert_pkg::POS_PAUSE_LO];
         state.long_reach <= autoneg_advert_pkg::RST_ADV_MID[autoneg_advert_pkg::POS_LONG_REACH];
         state.leader <= autoneg_advert_pkg::RST_ADV_MID[autoneg_advert_pkg::POS_LEADER];
         state.rd_data <= autoneg_advert_pkg::RST_READ_DATA;
         state.rd_valid <= 1'b0;
         state.page <= {autoneg_advert_pkg::RST_ADV_MID, autoneg_advert_pkg::RST_ADV_LOW};
         state.nonce <= autoneg_advert_pkg::RST_NONCE;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign O_RD_DATA = state.rd_data;
   assign O_RD_VALID = state.rd_valid;
   assign O_ADV_PAGE = state.page;
   assign O_TX_NONCE = state.nonce;

   rst_words_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (state.boot == autoneg_advert_pkg::BOOT_STRAP) |-> (O_ADV_PAGE == 32'h4000_0001))
      else $error("Advertisement words not at reset value");

   rd_low_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_RD_EN && hit_low) |=> (O_RD_VALID && (O_RD_DATA == $past(cur_low))))
      else $error("Low word readback wrong");

   next_page_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && hit_low) |=> (O_ADV_PAGE[15] == $past(I_WR_DATA[15])))
      else $error("Next page bit did not follow write");

   ack_set_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      I_PAGE_RECEIVED |=> O_ADV_PAGE[14] ##1 (O_ADV_PAGE[14] || $past(I_AN_RESTART) || $past(I_PAGE_RECEIVED)))
      else $error("Acknowledge not set by received page");

   ack_ro_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (!I_PAGE_RECEIVED && !I_AN_RESTART && (state.boot == autoneg_advert_pkg::BOOT_RUN))
      |=> $stable(state.ack))
      else $error("Acknowledge changed without cause");

   remote_fault_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && hit_low) |=> (O_ADV_PAGE[13] == $past(I_WR_DATA[13])))
      else $error("Remote fault bit did not follow write");

   role_forced_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && hit_low) |=> (O_ADV_PAGE[12] == $past(I_WR_DATA[12])))
      else $error("Forced role bit did not follow write");

   pause_field_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && hit_low) |=> (O_ADV_PAGE[11:10] == $past(I_WR_DATA[11:10])))
      else $error("Pause field did not follow write");

   selector_fixed_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (O_ADV_PAGE[4:0] == 5'h01) && !(O_RD_VALID && $past(hit_low) && (O_RD_DATA[4:0] != 5'h01)))
      else $error("Selector field not fixed");

   rd_mid_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_RD_EN && hit_mid) |=> (O_RD_DATA == $past(cur_mid)))
      else $error("Middle word readback wrong");

   long_reach_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && hit_mid) |=> (O_ADV_PAGE[30] == $past(I_WR_DATA[14])))
      else $error("Long reach bit did not follow write");

   role_strap_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (state.boot == autoneg_advert_pkg::BOOT_STRAP) |=> (O_ADV_PAGE[20] == $past(I_ROLE_STRAP)))
      else $error("Leader bit not loaded from strap");

   nonce_role_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (state.boot == autoneg_advert_pkg::BOOT_RUN) |-> (O_TX_NONCE[4] == O_ADV_PAGE[20]))
      else $error("Nonce bit 4 differs from leader bit");

   reserved_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (O_ADV_PAGE[9:5] == 5'h00) && (O_ADV_PAGE[31] == 1'b0) && (O_ADV_PAGE[29:21] == 9'h000)
      && (O_ADV_PAGE[19:16] == 4'h0))
      else $error("Reserved advertisement bit set");

   unmapped_read_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_RD_EN && !hit_low && !hit_mid) |=> (O_RD_VALID && (O_RD_DATA == 16'h0000)))
      else $error("Unmapped read not zero");

   ack_clear_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_AN_RESTART && !I_PAGE_RECEIVED) |=> !O_ADV_PAGE[14])
      else $error("Acknowledge not cleared by restart");

   ack_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (O_ADV_PAGE[14] && !I_AN_RESTART) |=> O_ADV_PAGE[14])
      else $error("Acknowledge dropped without restart");

   rd_idle_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      !I_RD_EN |=> !O_RD_VALID)
      else $error("Read valid without read strobe");

   low_guard_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && !hit_low && !I_PAGE_RECEIVED && !I_AN_RESTART) |=> $stable(O_ADV_PAGE[15:0]))
      else $error("Low word changed by foreign write");

   mid_guard_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && !hit_mid && (state.boot == autoneg_advert_pkg::BOOT_RUN)) |=> $stable(O_ADV_PAGE[31:16]))
      else $error("Middle word changed by foreign write");

   mid_valid_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_RD_EN && hit_mid) |=> O_RD_VALID)
      else $error("Middle word read without valid");

   leader_write_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_WR_EN && hit_mid && (state.boot == autoneg_advert_pkg::BOOT_RUN)) |=> (O_ADV_PAGE[20] == $past(I_WR_DATA[4])))
      else $error("Leader bit did not follow write");

   nonce_seed_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (state.boot == autoneg_advert_pkg::BOOT_RUN) |-> (O_TX_NONCE[3:0] == $past(I_NONCE_SEED[3:0])))
      else $error("Nonce low bits differ from seed");

endmodule : autoneg_base_page_advert_regs

// ---- verilog/autoneg_advert_pkg.sv ----
// Constants for the autonegotiation base page advertisement registers
package autoneg_advert_pkg;
   // Management device and register addresses
   localparam logic [4:0] MMD_AUTONEG = 5'h07;
   localparam logic [15:0] ADDR_ADV_LOW = 16'h0202;
   localparam logic [15:0] ADDR_ADV_MID = 16'h0203;
   // Reset values
   localparam logic [15:0] RST_ADV_LOW = 16'h0001;
   localparam logic [15:0] RST_ADV_MID = 16'h4000;
   localparam logic [15:0] RST_READ_DATA = 16'h0000;
   localparam logic [4:0] RST_NONCE = 5'h00;
   // Low word field positions
   localparam int POS_NEXT_PAGE = 15;
   localparam int POS_ACK = 14;
   localparam int POS_REMOTE_FAULT = 13;
   localparam int POS_ROLE_FORCED = 12;
   localparam int POS_PAUSE_HI = 11;
   localparam int POS_PAUSE_LO = 10;
   localparam int POS_SEL_HI = 4;
   localparam int POS_SEL_LO = 0;
   // Middle word field positions
   localparam int POS_LONG_REACH = 14;
   localparam int POS_LEADER = 4;
   // Fixed selector pattern
   localparam logic [4:0] SELECTOR_IEEE = 5'h01;
   // Bits of each word that software may change
   localparam logic [15:0] WR_MASK_LOW = 16'hBC00;
   localparam logic [15:0] WR_MASK_MID = 16'h4010;
   // Position of the leader bit in the nonce field
   localparam int POS_NONCE_ROLE = 4;
   // Start-up phase: strap capture, then normal operation
   typedef enum logic [0:0] {
      BOOT_STRAP = 1'b0,
      BOOT_RUN = 1'b1
   } boot_type;
endpackage : autoneg_advert_pkg

// ---- test/link_partner_model.sv ----
// Link partner model: acknowledges a page and captures the advertised base page
`timescale 1ns/1ps
module link_partner_model
(
   input wire logic i_clk,
   input wire logic i_send,
   input wire logic [31:0] i_adv_page,
   input wire logic [4:0] i_tx_nonce,
   output logic o_page_received,
   output logic [4:0] o_seed,
   output logic [31:0] o_seen_page,
   output logic [4:0] o_seen_nonce
);
   // Seed bit 4 is low, so a high nonce bit 4 can only come from the leader bit
   assign o_seed = 5'h05;
   initial
   begin
      o_page_received = 1'b0;
      o_seen_page = 32'h00000000;
      o_seen_nonce = 5'h00;
   end
   // One-cycle page pulse a cycle after the command, page captured as sent
   always @(posedge i_clk)
   begin
      o_page_received <= #1 i_send;
      if (i_send)
      begin
         o_seen_page <= i_adv_page;
         o_seen_nonce <= i_tx_nonce;
      end
   end
endmodule : link_partner_model

// ---- test/autoneg_base_page_advert_regs_bench.sv ----
// Bench for the advertisement register bank with a link partner model
`timescale 1ns/1ps
module autoneg_base_page_advert_regs_bench;
   logic clk, rst, wr_en, rd_en, strap, restart, send, rvalid, page_rx;
   logic [4:0] dev, seed, nonce, seen_nonce;
   logic [15:0] addr, wdata, rdata;
   logic [31:0] page, seen_page;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   autoneg_base_page_advert_regs u_autoneg_base_page_advert_regs (.I_REF_CLK(clk), .I_RST(rst), .I_MMD_DEV(dev),
      .I_REG_ADDR(addr), .I_WR_EN(wr_en), .I_WR_DATA(wdata), .I_RD_EN(rd_en), .I_ROLE_STRAP(strap),
      .I_PAGE_RECEIVED(page_rx), .I_AN_RESTART(restart), .I_NONCE_SEED(seed), .O_RD_DATA(rdata),
      .O_RD_VALID(rvalid), .O_ADV_PAGE(page), .O_TX_NONCE(nonce));
   link_partner_model u_link_partner_model (.i_clk(clk), .i_send(send), .i_adv_page(page), .i_tx_nonce(nonce),
      .o_page_received(page_rx), .o_seed(seed), .o_seen_page(seen_page), .o_seen_nonce(seen_nonce));
   task automatic conclude();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
      dev = d;
      addr = a;
      wdata = v;
      wr_en = 1'b1;
      tick();
      wr_en = 1'b0;
      tick();
   endtask : wr
   // Read strobe, then valid and data one cycle later, valid gone the next
   task automatic rd(input logic [4:0] d, input logic [15:0] a, input logic [15:0] exp);
      dev = d;
      addr = a;
      rd_en = 1'b1;
      tick();
      rd_en = 1'b0;
      chk(rvalid, 1'b1);
      chk(rdata, exp);
      tick();
      chk(rvalid, 1'b0);
   endtask : rd
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         conclude();
      end
   end
   initial
   begin
      rst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      dev = 5'h07;
      addr = 16'h0000;
      wdata = 16'h0000;
      strap = 1'b1;
      restart = 1'b0;
      send = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk(page, 32'h40000001);
      rst = 1'b0;
      tick();
      tick();
      rd(5'h07, 16'h0202, 16'h0001);
      rd(5'h07, 16'h0203, 16'h4010);
      chk(nonce, 5'h15);
      for (int i = 0; i < 16; i++)
      begin
         wr(5'h07, 16'h0202, 16'h0001 << i);
         rd(5'h07, 16'h0202, ((16'h0001 << i) & 16'hBC00) | 16'h0001);
      end
      wr(5'h07, 16'h0202, 16'hFFFF);
      rd(5'h07, 16'h0202, 16'hBC01);
      chk(page, 32'h4010BC01);
      send = 1'b1;
      tick();
      send = 1'b0;
      repeat (3) tick();
      chk(seen_page, 32'h4010BC01);
      chk(seen_nonce, 5'h15);
      rd(5'h07, 16'h0202, 16'hFC01);
      restart = 1'b1;
      tick();
      restart = 1'b0;
      tick();
      rd(5'h07, 16'h0202, 16'hBC01);
      wr(5'h07, 16'h0203, 16'hFFFF);
      rd(5'h07, 16'h0203, 16'h4010);
      wr(5'h07, 16'h0203, 16'h0000);
      rd(5'h07, 16'h0203, 16'h0000);
      chk(page, 32'h0000BC01);
      chk(nonce, 5'h05);
      wr(5'h06, 16'h0203, 16'h4010);
      rd(5'h07, 16'h0203, 16'h0000);
      rd(5'h06, 16'h0202, 16'h0000);
      rd(5'h07, 16'h0204, 16'h0000);
      rst = 1'b1;
      strap = 1'b0;
      tick();
      chk(page, 32'h40000001);
      chk(nonce, 5'h00);
      rst = 1'b0;
      tick();
      tick();
      rd(5'h07, 16'h0203, 16'h4000);
      rd(5'h07, 16'h0202, 16'h0001);
      chk(nonce, 5'h05);
      conclude();
   end
endmodule : autoneg_base_page_advert_regs_bench
